/* File: design/npmpc_cfg.svh */
// constants for the nibble phy mode and power control block
`ifndef NPMPC_CFG_SVH
`define NPMPC_CFG_SVH
`define NPMPC_ADDR_CTRL 4'h0
`define NPMPC_ADDR_IDLE 4'h1
`define NPMPC_ADDR_COMP 4'h2
`define NPMPC_ADDR_STAT 4'h3
`define NPMPC_ADDR_LOOP 4'h4
`define NPMPC_CTRL_RESET 16'h0000
`define NPMPC_IDLE_RESET 16'h0010
`define NPMPC_LOOP_RESET 16'h0000
`define NPMPC_CTRL_ASYNC 0
`define NPMPC_CTRL_TERM_EXT 1
`define NPMPC_CTRL_RX_EXT 2
`define NPMPC_CTRL_FORCE 3
`define NPMPC_CTRL_PWR_ON 4
`define NPMPC_CTRL_DES2 5
`define NPMPC_CTRL_SELFCAL 6
`define NPMPC_CTRL_FWDDN 7
`define NPMPC_CTRL_FWDUP 8
`define NPMPC_CTRL_STRB_EXT 9
`define NPMPC_CTRL_FREQ_LOW 10
`define NPMPC_COMP_SETTLE_NS 100
`define NPMPC_CLK_PERIOD_NS 10
`define NPMPC_COMP_SETTLE_CYC (`NPMPC_COMP_SETTLE_NS / `NPMPC_CLK_PERIOD_NS)
`define NPMPC_RDEN_LAG 2
`endif

/* File: design/npmpc_pkg.sv */
// types for the nibble phy mode and power control block
`default_nettype none
package npmpc_pkg;
  typedef enum logic [1:0] {
    NPMPC_PWR_ACTIVE,
    NPMPC_PWR_LAG,
    NPMPC_PWR_IDLE
  } npmpc_pwr_state_t;
endpackage
`default_nettype wire

/* File: design/npmpc_power_sm.sv */
// power state machine for the receiver and termination off outputs
`timescale 1ns/1ps
`default_nettype none
`include "npmpc_cfg.svh"
module npmpc_power_sm #(
  parameter int CNT_W = 16
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic div_tick,
  input wire logic phy_read_enable,
  input wire logic [CNT_W-1:0] idle_count,
  output logic sm_out,
  output logic [1:0] sm_state
);
  npmpc_pkg::npmpc_pwr_state_t state;
  logic [CNT_W-1:0] cnt;

  ////////////////////////////////////////////////////////////////////////
  // ticks are divided clock cycles; read enable wins over everything
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state <= npmpc_pkg::NPMPC_PWR_ACTIVE;
      cnt <= '0;
      sm_out <= 1'b1;
    end else if (ce && div_tick) begin
      case (state)
        npmpc_pkg::NPMPC_PWR_ACTIVE: begin
          sm_out <= 1'b1;
          if (!phy_read_enable) begin
            state <= npmpc_pkg::NPMPC_PWR_LAG;
            cnt <= CNT_W'(1);
          end
        end
        npmpc_pkg::NPMPC_PWR_LAG: begin
          if (phy_read_enable) begin
            state <= npmpc_pkg::NPMPC_PWR_ACTIVE;
          end else if (cnt >= CNT_W'(`NPMPC_RDEN_LAG)) begin
            // zero idle count would give a drop of no length, so skip it
            if (idle_count != '0) begin
              state <= npmpc_pkg::NPMPC_PWR_IDLE;
              sm_out <= 1'b0;
              cnt <= CNT_W'(1);
            end
          end else begin
            cnt <= cnt + CNT_W'(1);
          end
        end
        npmpc_pkg::NPMPC_PWR_IDLE: begin
          if (phy_read_enable) begin
            state <= npmpc_pkg::NPMPC_PWR_ACTIVE;
            sm_out <= 1'b1;
          end else if (cnt >= idle_count) begin
            // return to 1; drops again after the lag while read enable stays low
            state <= npmpc_pkg::NPMPC_PWR_ACTIVE;
            sm_out <= 1'b1;
            cnt <= '0;
          end else begin
            cnt <= cnt + CNT_W'(1);
          end
        end
        default: begin
          state <= npmpc_pkg::NPMPC_PWR_ACTIVE;
          sm_out <= 1'b1;
        end
      endcase
    end
  end

  assign sm_state = state;
endmodule
`default_nettype wire

/* File: design/npmpc_top.sv */
// top of the nibble phy mode and power control block
// Function
// - post-cal: ten more cycles, raise rx/tx compensation, resume
// - pre-cal: ten cycles after change raise all three enables
// - async receive mode forbids mixed and bidirectional use
// - async receive mode leaves transmit path untouched
// - async mode derives capture clock from pll clock; phase found by user
// - loopback lane routes transmit into own receive, still drives pad
// - loopback needs two lanes; only lane 0 accepts a strobe
// - receiver off high disables receiver; termination off high disables odt
// - power machine drops to 0 two divided cycles after read enable falls
// - stays 0 for the idle count of divided cycles, then returns to 1
// - at power on both outputs are 1 regardless of settings
// - both internal: machine drives both, force bit makes both 0
// - external source driven by fabric; internal one follows machine or 0
// - quarter delays compensate on global; io delays also need rx/tx enable
// - with full self calibration, complete once calibrated flag asserts
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "npmpc_cfg.svh"
module npmpc_top #(
  parameter int LANES = 6,
  parameter int DES_W = 4,
  parameter int CNT_W = 16
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic global_comp_enable,
  input wire logic rx_comp_enable,
  input wire logic tx_comp_enable,
  input wire logic calibrated_flag,
  input wire logic delay_ready_flag,
  input wire logic phy_read_enable,
  input wire logic [LANES-1:0] tx_lane_data,
  input wire logic [LANES-1:0] pad_rx_data,
  output logic [LANES-1:0] pad_tx_data,
  output logic [LANES-1:0] rx_lane_data,
  output logic quarter_comp_active,
  output logic rx_delay_comp_active,
  output logic tx_delay_comp_active,
  output logic delay_change_ok,
  output logic self_cal_done,
  output logic config_error,
  output logic receiver_off_out,
  output logic termination_off_out
);
  logic [15:0] ctrl;
  logic [CNT_W-1:0] idle_count;
  logic [LANES-1:0] lane_loopback_enable;
  logic [7:0] div_cnt;
  logic div_tick;
  logic sm_out;
  logic [1:0] sm_state;
  logic [4:0] settle_cnt;
  logic seen_cal;
  logic next_term;
  logic next_rx;
  logic next_err;

  // one flag per loose bit keeps the decode readable
  function automatic logic cbit(input logic [15:0] r, input int idx);
    return r[idx];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // register writes
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctrl <= `NPMPC_CTRL_RESET;
      idle_count <= CNT_W'(`NPMPC_IDLE_RESET);
      lane_loopback_enable <= LANES'(`NPMPC_LOOP_RESET);
    end else if (ce && reg_wr) begin
      case (reg_addr)
        `NPMPC_ADDR_CTRL: ctrl <= reg_wdata;
        `NPMPC_ADDR_IDLE: idle_count <= CNT_W'(reg_wdata);
        `NPMPC_ADDR_LOOP: lane_loopback_enable <= LANES'(reg_wdata);
        default: ;
      endcase
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      reg_rdata <= 16'h0000;
    end else if (ce) begin
      reg_rdata <= 16'h0000;
      if (reg_rd) begin
        case (reg_addr)
          `NPMPC_ADDR_CTRL: reg_rdata <= ctrl;
          `NPMPC_ADDR_IDLE: reg_rdata <= 16'(idle_count);
          `NPMPC_ADDR_COMP: reg_rdata <= {11'h000, settle_cnt};
          `NPMPC_ADDR_STAT: reg_rdata <= {8'h00, config_error, seen_cal, self_cal_done,
            sm_state, sm_out, receiver_off_out, termination_off_out};
          `NPMPC_ADDR_LOOP: reg_rdata <= 16'(lane_loopback_enable);
          default: reg_rdata <= 16'h0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // divided clock tick: pll clock over deserialisation ratio
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      div_cnt <= 8'h00;
      div_tick <= 1'b0;
    end else if (ce) begin
      div_tick <= (div_cnt == 8'(DES_W - 1));
      div_cnt <= (div_cnt == 8'(DES_W - 1)) ? 8'h00 : div_cnt + 8'h01;
    end
  end

  npmpc_power_sm #(.CNT_W(CNT_W)) u_sm (
    .ref_clk(ref_clk),
    .reset(reset),
    .ce(ce),
    .div_tick(div_tick),
    .phy_read_enable(phy_read_enable),
    .idle_count(idle_count),
    .sm_out(sm_out),
    .sm_state(sm_state)
  );

  ////////////////////////////////////////////////////////////////////////
  // source selection table for the power saving outputs
  always_comb begin
    next_term = 1'b1;
    next_rx = 1'b1;
    if (cbit(ctrl, `NPMPC_CTRL_PWR_ON)) begin
      // external side is driven by fabric; ours rests high here
      next_term = cbit(ctrl, `NPMPC_CTRL_TERM_EXT) ? 1'b1 :
        (cbit(ctrl, `NPMPC_CTRL_FORCE) ? 1'b0 : sm_out);
      next_rx = cbit(ctrl, `NPMPC_CTRL_RX_EXT) ? 1'b1 :
        (cbit(ctrl, `NPMPC_CTRL_FORCE) ? 1'b0 : sm_out);
    end
  end

  // until power-on bit set both stay 1; high means off
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      termination_off_out <= 1'b1;
      receiver_off_out <= 1'b1;
    end else if (ce) begin
      termination_off_out <= next_term;
      receiver_off_out <= next_rx;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // compensation gating; io delays need their own enable as well
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      quarter_comp_active <= 1'b0;
      rx_delay_comp_active <= 1'b0;
      tx_delay_comp_active <= 1'b0;
    end else if (ce) begin
      quarter_comp_active <= global_comp_enable;
      rx_delay_comp_active <= global_comp_enable && rx_comp_enable;
      tx_delay_comp_active <= global_comp_enable && tx_comp_enable;
    end
  end

  // settle counter: ten control cycles after rx/tx enables both drop
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      settle_cnt <= 5'h00;
      delay_change_ok <= 1'b0;
    end else if (ce) begin
      if (rx_comp_enable || tx_comp_enable) begin
        settle_cnt <= 5'h00;
        delay_change_ok <= 1'b0;
      end else if (settle_cnt < 5'(`NPMPC_COMP_SETTLE_CYC)) begin
        settle_cnt <= settle_cnt + 5'h01;
        delay_change_ok <= 1'b0;
      end else begin
        delay_change_ok <= seen_cal || delay_ready_flag;
      end
    end
  end

  // first calibrated flag is remembered; self cal done follows calibrated flag with self cal bit set, else delay ready
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      seen_cal <= 1'b0;
      self_cal_done <= 1'b0;
    end else if (ce) begin
      if (calibrated_flag) begin
        seen_cal <= 1'b1;
      end
      self_cal_done <= cbit(ctrl, `NPMPC_CTRL_SELFCAL) ? calibrated_flag
        : delay_ready_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // illegal setup flags, not enforced: fabric owns these choices
  always_comb begin
    next_err = 1'b0;
    if (cbit(ctrl, `NPMPC_CTRL_FREQ_LOW) && global_comp_enable) begin
      next_err = 1'b1;
    end
    if (cbit(ctrl, `NPMPC_CTRL_ASYNC)) begin
      if (global_comp_enable || cbit(ctrl, `NPMPC_CTRL_FWDDN) ||
          cbit(ctrl, `NPMPC_CTRL_FWDUP) || cbit(ctrl, `NPMPC_CTRL_STRB_EXT)) begin
        next_err = 1'b1;
      end
      if (cbit(ctrl, `NPMPC_CTRL_DES2) && cbit(ctrl, `NPMPC_CTRL_SELFCAL)) begin
        next_err = 1'b1;
      end
      // bidirectional use conflicts with async receive
      if (lane_loopback_enable != '0) begin
        next_err = 1'b1;
      end
    end
    if (lane_loopback_enable != '0 && (lane_loopback_enable[0] == 1'b0 ||
        $countones(lane_loopback_enable) < 2)) begin
      next_err = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      config_error <= 1'b0;
    end else if (ce) begin
      config_error <= next_err;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // datapath: transmit always reaches the pad, async mode does not touch it
  // receive capture runs on the local clock in every mode
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pad_tx_data <= '0;
      rx_lane_data <= '0;
    end else if (ce) begin
      pad_tx_data <= tx_lane_data;
      for (int i = 0; i < LANES; i++) begin
        rx_lane_data[i] <= lane_loopback_enable[i] ? tx_lane_data[i]
          : pad_rx_data[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  property p_power_on_high;
    @(posedge ref_clk) disable iff (reset)
      !cbit(ctrl, `NPMPC_CTRL_PWR_ON) && $past(!cbit(ctrl, `NPMPC_CTRL_PWR_ON)) && $past(ce)
        |-> receiver_off_out && termination_off_out;
  endproperty
  a_power_on_high: assert property (p_power_on_high)
    else $error("outputs low before power on");

  property p_force_low;
    @(posedge ref_clk) disable iff (reset)
      ce && cbit(ctrl, `NPMPC_CTRL_PWR_ON) && cbit(ctrl, `NPMPC_CTRL_FORCE)
        && !cbit(ctrl, `NPMPC_CTRL_RX_EXT) |=> !receiver_off_out;
  endproperty
  a_force_low: assert property (p_force_low)
    else $error("force bit did not clear receiver off");

  property p_rden_holds;
    @(posedge ref_clk) disable iff (reset)
      ce && div_tick && phy_read_enable |=> sm_out;
  endproperty
  a_rden_holds: assert property (p_rden_holds) else $error("machine low during read");

  property p_drop_after_lag;
    @(posedge ref_clk) disable iff (reset)
      $fell(sm_out) |-> $past(!phy_read_enable)
        && $past(sm_state) == 2'(npmpc_pkg::NPMPC_PWR_LAG);
  endproperty
  a_drop_after_lag: assert property (p_drop_after_lag) else $error("drop without lag");

  property p_loopback_path;
    @(posedge ref_clk) disable iff (reset)
      ce && lane_loopback_enable[0] |=> rx_lane_data[0] == $past(tx_lane_data[0])
        && pad_tx_data[0] == $past(tx_lane_data[0]);
  endproperty
  a_loopback_path: assert property (p_loopback_path) else $error("loopback lane wrong");

  property p_quarter_comp;
    @(posedge ref_clk) disable iff (reset)
      ce |=> quarter_comp_active == $past(global_comp_enable)
        && (rx_delay_comp_active -> quarter_comp_active);
  endproperty
  a_quarter_comp: assert property (p_quarter_comp)
    else $error("compensation gating wrong");

  property p_settle_ten;
    @(posedge ref_clk) disable iff (reset)
      delay_change_ok |-> settle_cnt == 5'(`NPMPC_COMP_SETTLE_CYC);
  endproperty
  a_settle_ten: assert property (p_settle_ten) else $error("change allowed too early");

  property p_sm_returns;
    @(posedge ref_clk) disable iff (reset)
      $rose(sm_out) |-> $past(sm_state) == 2'd2;
  endproperty
  a_sm_returns: assert property (p_sm_returns) else $error("rise not from idle");

  property p_term_follows_sm;
    @(posedge ref_clk) disable iff (reset)
      ce && cbit(ctrl, `NPMPC_CTRL_PWR_ON) && !cbit(ctrl, `NPMPC_CTRL_TERM_EXT)
        && !cbit(ctrl, `NPMPC_CTRL_FORCE) |=> termination_off_out == $past(sm_out);
  endproperty
  a_term_follows_sm: assert property (p_term_follows_sm)
    else $error("termination off not following machine");

  property p_ext_rests_high;
    @(posedge ref_clk) disable iff (reset)
      ce && cbit(ctrl, `NPMPC_CTRL_PWR_ON) && cbit(ctrl, `NPMPC_CTRL_RX_EXT)
        |=> receiver_off_out;
  endproperty
  a_ext_rests_high: assert property (p_ext_rests_high)
    else $error("external receiver source not resting high");

  property p_cal_done_follows;
    @(posedge ref_clk) disable iff (reset)
      ce && cbit(ctrl, `NPMPC_CTRL_SELFCAL) |=> self_cal_done == $past(calibrated_flag);
  endproperty
  a_cal_done_follows: assert property (p_cal_done_follows)
    else $error("self cal done not following calibrated flag");

  property p_idle_abort;
    @(posedge ref_clk) disable iff (reset)
      ce && div_tick && phy_read_enable && sm_state == 2'(npmpc_pkg::NPMPC_PWR_IDLE)
        |=> sm_state == 2'(npmpc_pkg::NPMPC_PWR_ACTIVE);
  endproperty
  a_idle_abort: assert property (p_idle_abort)
    else $error("read enable did not abort idle wait");

  property p_lane0_strobe;
    @(posedge ref_clk) disable iff (reset)
      ce && lane_loopback_enable != '0 && !lane_loopback_enable[0] |=> config_error;
  endproperty
  a_lane0_strobe: assert property (p_lane0_strobe)
    else $error("loopback without strobe lane not flagged");
endmodule
`default_nettype wire

/* File: verif/npmpc_fabric_model.sv */
// fabric-side model that walks the compensation enables through a delay change
`timescale 1ns/1ps
`default_nettype none
module npmpc_fabric_model (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic go,
  input wire logic pre_cal,
  input wire logic delay_ready_flag,
  input wire logic [2:0] idle_val,
  output logic global_comp_enable,
  output logic rx_comp_enable,
  output logic tx_comp_enable,
  output logic [1:0] phase
);
  logic [3:0] cnt;
  ////////////////////////////////////////////////////////////////////////
  // idle follows idle_val; a change drops rx/tx, waits ten, modifies, waits ten
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      phase <= 2'h0;
      cnt <= 4'h0;
      {global_comp_enable, rx_comp_enable, tx_comp_enable} <= 3'h0;
    end else if (phase == 2'h0) begin
      {global_comp_enable, rx_comp_enable, tx_comp_enable} <= idle_val;
      if (go) begin
        phase <= 2'h1;
      end
    end else if (phase == 2'h1) begin
      // before first calibration global stays low and rx/tx wait for delay ready
      global_comp_enable <= !pre_cal;
      if (!pre_cal || delay_ready_flag) begin
        rx_comp_enable <= 1'b0;
        tx_comp_enable <= 1'b0;
        cnt <= 4'h0;
        phase <= 2'h2;
      end
    end else if (cnt != 4'h9) begin
      cnt <= cnt + 4'h1;
    end else begin
      // phase 3 is the window in which delays may change
      cnt <= 4'h0;
      phase <= phase + 2'h1;
      if (phase == 2'h3) begin
        {global_comp_enable, rx_comp_enable, tx_comp_enable} <= 3'h7;
      end
    end
  end
endmodule
`default_nettype wire

/* File: verif/npmpc_top_tb.sv */
// self-checking bench for the nibble phy mode and power control block
`timescale 1ns/1ps
`default_nettype none
`include "npmpc_cfg.svh"
module npmpc_top_tb;
  localparam int DES_W = 4;
  logic ref_clk = 1'b0, reset = 1'b1, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic cal = 1'b0, dly = 1'b0, rden = 1'b1, go = 1'b0, pre_cal = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, v, c, lp;
  logic [5:0] tx_d = 6'h00, pad_d = 6'h00, pad_tx, rx_d;
  logic [2:0] idle_val = 3'h0;
  logic [1:0] phase;
  logic qa, ra, ta, dco, scd, cerr, rx_off, term_off, g, rxe, txe;
  int num_errors = 0, num_checks = 0, n;
  npmpc_top #(.LANES(6), .DES_W(DES_W), .CNT_W(16)) i_dut (.ref_clk(ref_clk),
    .reset(reset), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .global_comp_enable(g), .rx_comp_enable(rxe),
    .tx_comp_enable(txe), .calibrated_flag(cal), .delay_ready_flag(dly),
    .phy_read_enable(rden), .tx_lane_data(tx_d), .pad_rx_data(pad_d), .pad_tx_data(pad_tx),
    .rx_lane_data(rx_d), .quarter_comp_active(qa), .rx_delay_comp_active(ra),
    .tx_delay_comp_active(ta), .delay_change_ok(dco), .self_cal_done(scd),
    .config_error(cerr), .receiver_off_out(rx_off), .termination_off_out(term_off));
  npmpc_fabric_model i_fab (.ref_clk(ref_clk), .reset(reset), .go(go), .pre_cal(pre_cal),
    .delay_ready_flag(dly), .idle_val(idle_val), .global_comp_enable(g),
    .rx_comp_enable(rxe), .tx_comp_enable(txe), .phase(phase));
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // waits on the receiver output (sel 0) or model phase; a hang ends the run
  task automatic wait_ev(input int sel, input logic [1:0] val);
    n = 0;
    while (((sel == 0) ? {1'b0, rx_off} : phase) !== val) begin
      tick(1);
      n++;
      if (n == 200) begin
        num_errors++;
        print_verdict();
      end
    end
  endtask
  // {termination, receiver}; an external source rests at 1 while fabric drives the pad
  function automatic logic [1:0] exp_off(input logic [15:0] k, input logic sm);
    if (!k[`NPMPC_CTRL_PWR_ON]) return 2'h3;
    exp_off[1] = k[`NPMPC_CTRL_TERM_EXT] | (sm & !k[`NPMPC_CTRL_FORCE]);
    exp_off[0] = k[`NPMPC_CTRL_RX_EXT] | (sm & !k[`NPMPC_CTRL_FORCE]);
  endfunction
  // one delay change walked by the fabric model, before or after first calibration
  task automatic change(input logic pre);
    @(posedge ref_clk);
    pre_cal <= pre;
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    idle_val <= 3'h7;
    if (pre) begin
      tick(5);
      chk("ok_waiting_ready", 16'h0000, dco);
      @(posedge ref_clk);
      dly <= 1'b1;
    end
    wait_ev(1, 2'h2);
    tick(3);
    chk("ok_too_early", 16'h0000, dco);
    wait_ev(1, 2'h3);
    tick(2);
    chk("ok_window", 16'h0001, dco);
    wait_ev(1, 2'h0);
    tick(2);
    chk("comp_resumed", 16'h0007, {qa, ra, ta});
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h0b4fd8f1));
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    tick(1);
    chk("off_at_reset", 16'h0003, {term_off, rx_off});
    rd(`NPMPC_ADDR_IDLE, v);
    chk("idle_reset", `NPMPC_IDLE_RESET, v);
    rd(4'hf, v);
    chk("unmapped", 16'h0000, v);
    rd(`NPMPC_ADDR_STAT, v);
    chk("stat_off", 16'h0003, v[1:0]);
    // illegal async combination is flagged, self cal source follows the mode bit
    wr(`NPMPC_ADDR_CTRL, 16'h0181);
    tick(2);
    chk("cfg_err", 16'h0001, cerr);
    wr(`NPMPC_ADDR_CTRL, 16'h0061);
    tick(2);
    chk("des2_selfcal", 16'h0001, cerr);
    wr(`NPMPC_ADDR_CTRL, 16'h0021);
    tick(2);
    chk("des2_clean", 16'h0000, cerr);
    for (int i = 0; i < 16; i++) begin
      if (i % 8 == 0) begin
        wr(`NPMPC_ADDR_CTRL, (i == 0) ? 16'h0040 : 16'h0000);
      end
      @(posedge ref_clk);
      {cal, dly} <= 2'($urandom);
      tick(2);
      chk("self_cal", (i < 8) ? cal : dly, scd);
    end
    // random enables reach the compensation outputs a cycle behind the model
    for (int i = 0; i < 20; i++) begin
      @(posedge ref_clk);
      idle_val <= 3'($urandom);
      tick(2);
      chk("comp", {g, g & rxe, g & txe}, {qa, ra, ta});
    end
    // low reference frequency with global compensation on is flagged
    wr(`NPMPC_ADDR_CTRL, 16'h0400);
    @(posedge ref_clk);
    idle_val <= 3'h4;
    tick(3);
    chk("freq_low_err", 16'h0001, cerr);
    // second reset mid-run clears the calibrated memory for the pre-cal walk
    @(posedge ref_clk);
    reset <= 1'b1;
    {cal, dly} <= 2'h0;
    idle_val <= 3'h3;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    tick(1);
    chk("off_mid_reset", 16'h0003, {term_off, rx_off});
    rd(`NPMPC_ADDR_STAT, v);
    chk("seen_cal_clr", 16'h0000, v[6]);
    change(1'b1);
    @(posedge ref_clk);
    cal <= 1'b1;
    change(1'b0);
    // loopback lanes take transmit data, the pad still gets the transmit copy (async mode set)
    // lanes run edge aligned, the receive side does the centring
    lp = 16'($urandom) & 16'h003f;
    wr(`NPMPC_ADDR_LOOP, lp);
    wr(`NPMPC_ADDR_CTRL, 16'h0001);
    rd(`NPMPC_ADDR_LOOP, v);
    chk("loop_reg", lp, v);
    for (int i = 0; i < 20; i++) begin
      @(posedge ref_clk);
      tx_d <= 6'($urandom);
      pad_d <= 6'($urandom) & ~lp[5:0];
      tick(1);
      chk("rx_lane", (lp[5:0] & tx_d) | (~lp[5:0] & pad_d), rx_d);
      chk("pad_tx", tx_d, pad_tx);
    end
    // lane 0 must carry the strobe and a second lane the data
    wr(`NPMPC_ADDR_CTRL, 16'h0000);
    for (int i = 0; i < 3; i++) begin
      lp = (i == 0) ? 16'h0001 : (i == 1) ? 16'h0006 : 16'h0003;
      wr(`NPMPC_ADDR_LOOP, lp);
      tick(2);
      chk("lane_count", (i < 2) ? 16'h0001 : 16'h0000, cerr);
    end
    // every source, force and power-on mix while reads keep the machine at 1
    for (int i = 0; i < 16; i++) begin
      c = 16'(i) << 1;
      wr(`NPMPC_ADDR_CTRL, c);
      tick(2);
      chk("off_pair", exp_off(c, 1'b1), {term_off, rx_off});
    end
    wr(`NPMPC_ADDR_CTRL, 16'h0010);
    wr(`NPMPC_ADDR_IDLE, 16'h0003);
    @(posedge ref_clk);
    rden <= 1'b0;
    wait_ev(0, 2'h0);
    chk("fall_lag", 16'h0001, (n >= 2 * DES_W && n <= 3 * DES_W + 3));
    chk("term_low", 16'h0000, term_off);
    wait_ev(0, 2'h1);
    chk("idle_len", 16'(3 * DES_W), 16'(n));
    wait_ev(0, 2'h0);
    @(posedge ref_clk);
    rden <= 1'b1;
    wait_ev(0, 2'h1);
    chk("abort", 16'h0001, (n <= DES_W + 2));
    // a write while the clock enable is low must be lost
    @(posedge ref_clk);
    ce <= 1'b0;
    wr(`NPMPC_ADDR_IDLE, 16'h0005);
    @(posedge ref_clk);
    ce <= 1'b1;
    rd(`NPMPC_ADDR_IDLE, v);
    chk("ce_frozen", 16'h0003, v);
    tick(30);
    chk("held_on", 16'h0001, rx_off);
    print_verdict();
  end
endmodule
`default_nettype wire
